// ==== hdl/csp_params.svh ====
`ifndef CSP_PARAMS_SVH
`define CSP_PARAMS_SVH

// ----------------------------------------
// Payload word numbers of the class blocks
// ----------------------------------------
`define CSP_C2_FIRST_WORD 8'h0D
`define CSP_C3_FIRST_WORD 8'h11
`define CSP_LAST_WORD 8'h14
`define CSP_TX_LAST_CNT 3'h7

// ----------------------------------------
// Bit positions inside a class block word
// ----------------------------------------
`define CSP_VALID_BIT 31
`define CSP_PRIO_BIT 23
`define CSP_PREF_BIT 22
`define CSP_CSYNC_BIT 19
`define CSP_SEQID_BIT 18
`define CSP_HI_MSB 31
`define CSP_HI_LSB 16
`define CSP_LO_MSB 15
`define CSP_SEQ_MSB 23
`define CSP_SEQ_LSB 16
`define CSP_RXSZ_MSB 11

// ----------------------------------------
// Default login values
// ----------------------------------------
`define CSP_DEF_RX_SIZE 12'h100
`define CSP_DEF_CONC 8'h01
`define CSP_DEF_OPEN 8'h01
`define CSP_DEF_E2E 16'h0001

`endif

// ==== hdl/csp_pkg.sv ====
package csp_pkg;

	// Kind of login payload carried
	typedef enum logic [1:0] {csp_plogi_req, csp_plogi_acc, csp_flogi_req, csp_flogi_acc} csp_kind_type;

	// Fabric priority outcome, coded as {request bit, accept bit}
	typedef enum logic [1:0] {csp_prio_none, csp_prio_fab_capable, csp_prio_fab_lacks, csp_prio_agreed} csp_prio_type;

	typedef enum logic {csp_tx_idle, csp_tx_send} csp_tx_state_type;

	// Parameters learnt from a peer port
	typedef struct packed {
		logic valid;
		logic prio;
		logic pref;
		logic seqid;
		logic csync;
		logic [11:0] rx_size;
		logic [7:0] conc;
		logic [15:0] e2e;
		logic [7:0] open_seq;
	} csp_peer_type;

	// Parameters learnt from the fabric
	typedef struct packed {
		logic valid;
		csp_prio_type prio;
		logic pref;
		logic csync;
	} csp_fab_type;

endpackage

// ==== hdl/csp_word_builder.sv ====
`timescale 1ns/1ps
`include "csp_params.svh"

module csp_word_builder (
	input wire csp_pkg::csp_kind_type kind_i,
	input wire logic cls_i,
	input wire logic [1:0] widx_i,
	input wire logic class_en_i,
	input wire logic prio_i,
	input wire logic pref_i,
	input wire logic seqid_i,
	input wire logic csync_i,
	input wire logic [15:0] init_ctl_i,
	input wire logic [15:0] rcp_ctl_i,
	input wire logic [11:0] rx_size_i,
	input wire logic [7:0] conc_i,
	input wire logic [15:0] e2e_i,
	input wire logic [7:0] open_i,
	output logic [31:0] word_o
);

	logic plogi;
	logic facc;

	assign plogi = (kind_i == csp_pkg::csp_plogi_req) || (kind_i == csp_pkg::csp_plogi_acc);
	assign facc = (kind_i == csp_pkg::csp_flogi_acc);

	// Word layout by kind; unused and reserved fields stay zero
	always_comb begin
		word_o = 32'h0000_0000;
		case (widx_i)
			2'd0: begin
				word_o[`CSP_VALID_BIT] = 1'b1;
				word_o[`CSP_PRIO_BIT] = prio_i;
				word_o[`CSP_PREF_BIT] = pref_i;
				if (!facc) begin
					word_o[`CSP_LO_MSB:0] = init_ctl_i;
				end
			end
			2'd1: begin
				word_o[`CSP_HI_MSB:`CSP_HI_LSB] = rcp_ctl_i;
				word_o[`CSP_CSYNC_BIT] = csync_i;
				word_o[`CSP_SEQID_BIT] = plogi & seqid_i;
				if (plogi) begin
					word_o[`CSP_RXSZ_MSB:0] = rx_size_i;
				end
			end
			2'd2: begin
				if (!facc) begin
					word_o[`CSP_SEQ_MSB:`CSP_SEQ_LSB] = conc_i;
					word_o[`CSP_LO_MSB:0] = cls_i ? 16'h0000 : e2e_i;
				end
			end
			2'd3: begin
				// Obsolete in a fabric accept
				if (!facc) begin
					word_o[`CSP_SEQ_MSB:`CSP_SEQ_LSB] = open_i;
				end
			end
			default: word_o = 32'h0000_0000;
		endcase
		// An unsupported class sends an all-zero block
		if (!class_en_i) begin
			word_o = 32'h0000_0000;
		end
	end

endmodule // csp_word_builder

// ==== hdl/csp_frame_gate.sv ====
`timescale 1ns/1ps

module csp_frame_gate (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic fr_valid_i,
	input wire logic fr_cls_i,
	input wire logic fr_prio_en_i,
	input wire logic fr_prio_nz_i,
	input wire logic fr_csctl_nz_i,
	input wire logic [1:0] tol_prio_i,
	input wire logic [1:0] tol_pref_i,
	output logic fr_done_o,
	output logic fr_accept_o
);

	logic done_reg, done_next;
	logic acc_reg, acc_next;
	logic bad_prio, bad_csctl;

	// The preference field is never looked at here
	assign bad_prio = fr_prio_en_i && fr_prio_nz_i && !tol_prio_i[fr_cls_i];
	assign bad_csctl = !fr_prio_en_i && fr_csctl_nz_i && !tol_pref_i[fr_cls_i];

	always_comb begin
		done_next = fr_valid_i;
		acc_next = acc_reg;
		if (fr_valid_i) begin
			acc_next = !bad_prio && !bad_csctl;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			done_reg <= 1'b0;
			acc_reg <= 1'b0;
		end else begin
			done_reg <= done_next;
			acc_reg <= acc_next;
		end
	end

	assign fr_done_o = done_reg;
	assign fr_accept_o = acc_reg;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	a_prio_tolerated: assert property (fr_valid_i && fr_prio_en_i && tol_prio_i[fr_cls_i] |=> fr_done_o && fr_accept_o)
		else $error("tolerated priority frame rejected");
	a_csctl_tolerated: assert property (fr_valid_i && !fr_prio_en_i && tol_pref_i[fr_cls_i] |=> fr_accept_o)
		else $error("tolerated cs_ctl frame rejected");
	c_frame_reject: cover property (fr_valid_i ##1 fr_done_o && !fr_accept_o);

endmodule // csp_frame_gate

// ==== hdl/csp_codec.sv ====
// Contract
// - Word 0 bit 31 marks a class supported; one obliges support.
// - A class block with validity zero is ignored entirely.
// - Class 2 block sits in payload words 13 to 16.
// - Class 3 block sits in payload words 17 to 20.
// - Fabric request layout: options, controls, sequences, credit, open sequences.
// - Port login uses the fabric request layout plus receive size bits 11-0.
// - Fabric accept carries only options and recipient control; rest reserved or obsolete.
// - Port login defaults: size 256, sequences 1, open 1, credit 1 class 2.
// - Word 1 bit 18 unique sequence id, default 0, port login only.
// - Word 1 bit 19 clock sync capability, default 0, all logins.
// - Port login bit 23 declares tolerance of non-zero priority.
// - A priority-tolerant port never rejects frames for non-zero priority.
// - Send non-zero priority only when peer port and fabric both agreed.
// - Fabric priority agreed only when request and accept both set bit 23.
// - Fabric priority bit pairs decode to none, capable, lacking, agreed.
// - Bit 22 declares class-specific control tolerance; tolerant port never rejects.
// - With preference declared, initiator may request preferred delivery.
// - As recipient with preference declared, ignore the preference field.
`timescale 1ns/1ps
`include "csp_params.svh"

module csp_codec (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic login_reset_i,
	input wire logic [1:0] loc_class_en_i,
	input wire logic [1:0] loc_prio_i,
	input wire logic [1:0] loc_pref_i,
	input wire logic loc_seqid_uniq_i,
	input wire logic loc_csync_i,
	input wire logic [15:0] loc_init_ctl_i,
	input wire logic [15:0] loc_rcp_ctl_i,
	input wire logic [11:0] loc_rx_size_i,
	input wire logic [7:0] loc_conc_seq_i,
	input wire logic [15:0] loc_e2e_credit_i,
	input wire logic [7:0] loc_open_seq_i,
	input wire logic tx_start_i,
	input wire csp_pkg::csp_kind_type tx_kind_i,
	input wire logic tx_ready_i,
	output logic tx_valid_o,
	output logic [7:0] tx_index_o,
	output logic [31:0] tx_word_o,
	output logic tx_busy_o,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_index_i,
	input wire logic [31:0] rx_word_i,
	input wire logic rx_done_i,
	input wire csp_pkg::csp_kind_type rx_kind_i,
	output logic [1:0] peer_class_valid_o,
	output logic [1:0] peer_prio_o,
	output logic [1:0] peer_pref_o,
	output logic [1:0] peer_seqid_uniq_o,
	output logic [1:0] peer_csync_o,
	output logic [1:0][11:0] peer_rx_size_o,
	output logic [1:0][7:0] peer_conc_seq_o,
	output logic [1:0][15:0] peer_e2e_credit_o,
	output logic [1:0][7:0] peer_open_seq_o,
	output logic [1:0] fab_class_valid_o,
	output csp_pkg::csp_prio_type [1:0] fab_prio_o,
	output logic [1:0] fab_pref_o,
	output logic [1:0] fab_csync_o,
	input wire logic fr_valid_i,
	input wire logic fr_cls_i,
	input wire logic fr_prio_en_i,
	input wire logic fr_prio_nz_i,
	input wire logic fr_csctl_nz_i,
	output logic fr_done_o,
	output logic fr_accept_o,
	input wire logic tx_frame_cls_i,
	input wire logic [7:0] tx_frame_prio_i,
	input wire logic tx_frame_pref_i,
	output logic [7:0] tx_frame_prio_o,
	output logic tx_frame_pref_o
);

	// ----------------------------------------
	// Transmit of the two class blocks
	// ----------------------------------------
	csp_pkg::csp_tx_state_type state_reg, state_next;
	csp_pkg::csp_kind_type kind_reg, kind_next;
	logic [2:0] cnt_reg, cnt_next;
	logic valid_reg, valid_next;
	logic [31:0] word_reg, word_next;
	logic [7:0] idx_reg, idx_next;
	logic [2:0] ld_cnt;
	csp_pkg::csp_kind_type ld_kind;
	logic [31:0] bld_word;

	// Builder sees the word about to be loaded, not the one on the port
	assign ld_cnt = (state_reg == csp_pkg::csp_tx_idle) ? 3'd0 : cnt_reg + 3'd1;
	assign ld_kind = (state_reg == csp_pkg::csp_tx_idle) ? tx_kind_i : kind_reg;

	csp_word_builder u_builder (
		.kind_i(ld_kind),
		.cls_i(ld_cnt[2]),
		.widx_i(ld_cnt[1:0]),
		.class_en_i(loc_class_en_i[ld_cnt[2]]),
		.prio_i(loc_prio_i[ld_cnt[2]]),
		.pref_i(loc_pref_i[ld_cnt[2]]),
		.seqid_i(loc_seqid_uniq_i),
		.csync_i(loc_csync_i),
		.init_ctl_i(loc_init_ctl_i),
		.rcp_ctl_i(loc_rcp_ctl_i),
		.rx_size_i(loc_rx_size_i),
		.conc_i(loc_conc_seq_i),
		.e2e_i(loc_e2e_credit_i),
		.open_i(loc_open_seq_i),
		.word_o(bld_word)
	);

	// Eight words, class 2 first; the sink may stall with tx_ready_i
	always_comb begin
		state_next = state_reg;
		kind_next = kind_reg;
		cnt_next = cnt_reg;
		valid_next = valid_reg;
		word_next = word_reg;
		idx_next = idx_reg;
		case (state_reg)
			csp_pkg::csp_tx_idle: begin
				if (tx_start_i) begin
					kind_next = tx_kind_i;
					cnt_next = 3'd0;
					valid_next = 1'b1;
					word_next = bld_word;
					idx_next = `CSP_C2_FIRST_WORD;
					state_next = csp_pkg::csp_tx_send;
				end
			end
			csp_pkg::csp_tx_send: begin
				if (tx_ready_i) begin
					if (cnt_reg == `CSP_TX_LAST_CNT) begin
						valid_next = 1'b0;
						state_next = csp_pkg::csp_tx_idle;
					end else begin
						cnt_next = ld_cnt;
						word_next = bld_word;
						idx_next = `CSP_C2_FIRST_WORD + {5'd0, ld_cnt};
					end
				end
			end
			default: state_next = csp_pkg::csp_tx_idle;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			state_reg <= csp_pkg::csp_tx_idle;
			kind_reg <= csp_pkg::csp_plogi_req;
			cnt_reg <= 3'd0;
			valid_reg <= 1'b0;
			word_reg <= 32'h0000_0000;
			idx_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			kind_reg <= kind_next;
			cnt_reg <= cnt_next;
			valid_reg <= valid_next;
			word_reg <= word_next;
			idx_reg <= idx_next;
		end
	end

	assign tx_valid_o = valid_reg;
	assign tx_word_o = word_reg;
	assign tx_index_o = idx_reg;
	assign tx_busy_o = (state_reg != csp_pkg::csp_tx_idle);

	// ----------------------------------------
	// Receive capture of words 13 to 20
	// ----------------------------------------
	logic [31:0] cap_reg [8];
	logic [31:0] cap_next [8];
	logic [7:0] rx_off;
	logic rx_in_win;
	logic rx_plogi;

	assign rx_off = rx_index_i - `CSP_C2_FIRST_WORD;
	assign rx_in_win = (rx_index_i >= `CSP_C2_FIRST_WORD) && (rx_index_i <= `CSP_LAST_WORD);
	assign rx_plogi = (rx_kind_i == csp_pkg::csp_plogi_req) || (rx_kind_i == csp_pkg::csp_plogi_acc);

	// Cleared at commit so a missing word 0 reads as an invalid class
	always_comb begin
		cap_next = cap_reg;
		if (rx_done_i) begin
			cap_next = '{default: 32'h0000_0000};
		end else if (rx_valid_i && rx_in_win) begin
			cap_next[rx_off[2:0]] = rx_word_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			cap_reg <= '{default: 32'h0000_0000};
		end else begin
			cap_reg <= cap_next;
		end
	end

	// ----------------------------------------
	// Per class interpretation
	// ----------------------------------------
	logic [1:0] prio_ok;

	generate
		for (genvar k = 0; k < 2; k++) begin : g_cls
			csp_pkg::csp_peer_type peer_reg, peer_next, dflt;
			csp_pkg::csp_fab_type fab_reg, fab_next;
			logic [31:0] w0, w1, w2, w3;

			assign w0 = cap_reg[4 * k];
			assign w1 = cap_reg[4 * k + 1];
			assign w2 = cap_reg[4 * k + 2];
			assign w3 = cap_reg[4 * k + 3];

			// Values that stand until a port login completes
			always_comb begin
				dflt = '0;
				dflt.rx_size = `CSP_DEF_RX_SIZE;
				dflt.conc = `CSP_DEF_CONC;
				dflt.open_seq = `CSP_DEF_OPEN;
				dflt.e2e = (k == 0) ? `CSP_DEF_E2E : 16'h0000;
			end

			// Only named fields are read; reserved bits drop out here
			always_comb begin
				peer_next = peer_reg;
				fab_next = fab_reg;
				if (login_reset_i) begin
					peer_next = dflt;
					fab_next = '0;
				end else if (rx_done_i && rx_plogi) begin
					peer_next = dflt;
					if (w0[`CSP_VALID_BIT]) begin
						peer_next.valid = 1'b1;
						peer_next.prio = w0[`CSP_PRIO_BIT];
						peer_next.pref = w0[`CSP_PREF_BIT];
						peer_next.csync = w1[`CSP_CSYNC_BIT];
						peer_next.seqid = w1[`CSP_SEQID_BIT];
						peer_next.rx_size = w1[`CSP_RXSZ_MSB:0];
						peer_next.conc = w2[`CSP_SEQ_MSB:`CSP_SEQ_LSB];
						peer_next.open_seq = w3[`CSP_SEQ_MSB:`CSP_SEQ_LSB];
						if (k == 0) begin
							peer_next.e2e = w2[`CSP_LO_MSB:0];
						end
					end
				end else if (rx_done_i && rx_kind_i == csp_pkg::csp_flogi_acc) begin
					// Accept halves below bit 16 and words 2, 3 unused
					fab_next.valid = w0[`CSP_VALID_BIT];
					fab_next.prio = csp_pkg::csp_prio_type'({loc_prio_i[k],
						w0[`CSP_VALID_BIT] & w0[`CSP_PRIO_BIT]});
					fab_next.pref = w0[`CSP_VALID_BIT] & w0[`CSP_PREF_BIT];
					fab_next.csync = w0[`CSP_VALID_BIT] & w1[`CSP_CSYNC_BIT];
				end
			end

			always_ff @(posedge clock_i) begin
				if (reset_i) begin
					peer_reg <= '{valid: 1'b0, prio: 1'b0, pref: 1'b0, seqid: 1'b0, csync: 1'b0,
						rx_size: `CSP_DEF_RX_SIZE, conc: `CSP_DEF_CONC,
						e2e: (k == 0) ? `CSP_DEF_E2E : 16'h0000, open_seq: `CSP_DEF_OPEN};
					fab_reg <= '0;
				end else begin
					peer_reg <= peer_next;
					fab_reg <= fab_next;
				end
			end

			// Priority needs both the peer port and the fabric
			assign prio_ok[k] = peer_reg.valid && peer_reg.prio && (fab_reg.prio == csp_pkg::csp_prio_agreed);

			assign peer_class_valid_o[k] = peer_reg.valid;
			assign peer_prio_o[k] = peer_reg.prio;
			assign peer_pref_o[k] = peer_reg.pref;
			assign peer_seqid_uniq_o[k] = peer_reg.seqid;
			assign peer_csync_o[k] = peer_reg.csync;
			assign peer_rx_size_o[k] = peer_reg.rx_size;
			assign peer_conc_seq_o[k] = peer_reg.conc;
			assign peer_e2e_credit_o[k] = peer_reg.e2e;
			assign peer_open_seq_o[k] = peer_reg.open_seq;
			assign fab_class_valid_o[k] = fab_reg.valid;
			assign fab_prio_o[k] = fab_reg.prio;
			assign fab_pref_o[k] = fab_reg.pref;
			assign fab_csync_o[k] = fab_reg.csync;
		end
	endgenerate

	// ----------------------------------------
	// Outgoing frame header fields
	// ----------------------------------------
	logic [7:0] fprio_reg, fprio_next;
	logic fpref_reg, fpref_next;

	// Unagreed priority is forced to zero rather than risk loss
	always_comb begin
		fprio_next = prio_ok[tx_frame_cls_i] ? tx_frame_prio_i : 8'h00;
		fpref_next = tx_frame_pref_i && loc_pref_i[tx_frame_cls_i] && loc_class_en_i[tx_frame_cls_i];
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			fprio_reg <= 8'h00;
			fpref_reg <= 1'b0;
		end else begin
			fprio_reg <= fprio_next;
			fpref_reg <= fpref_next;
		end
	end

	assign tx_frame_prio_o = fprio_reg;
	assign tx_frame_pref_o = fpref_reg;

	// ----------------------------------------
	// Incoming frame acceptance
	// ----------------------------------------
	csp_frame_gate u_gate (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.fr_valid_i(fr_valid_i),
		.fr_cls_i(fr_cls_i),
		.fr_prio_en_i(fr_prio_en_i),
		.fr_prio_nz_i(fr_prio_nz_i),
		.fr_csctl_nz_i(fr_csctl_nz_i),
		.tol_prio_i(loc_class_en_i & loc_prio_i),
		.tol_pref_i(loc_class_en_i & loc_pref_i),
		.fr_done_o(fr_done_o),
		.fr_accept_o(fr_accept_o)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	a_tx_first_word: assert property (!tx_busy_o && tx_start_i |=> tx_valid_o && tx_index_o == 8'h0D)
		else $error("block does not start at word 13");
	a_tx_class3_base: assert property (tx_valid_o && tx_ready_i && tx_index_o == 8'h10 |=> tx_index_o == 8'h11)
		else $error("class 3 block not after word 16");
	a_tx_valid_bit: assert property (!tx_busy_o && tx_start_i |=> tx_word_o[31] == $past(loc_class_en_i[0]))
		else $error("validity bit wrong");
	a_facc_low_zero: assert property (tx_valid_o && kind_reg == csp_pkg::csp_flogi_acc |-> tx_word_o[15:0] == 16'h0000)
		else $error("fabric accept low half not zero");
	a_invalid_ignored: assert property (rx_done_i && rx_plogi && !cap_reg[0][31] && !login_reset_i
		|=> !peer_class_valid_o[0] && peer_rx_size_o[0] == 12'h100)
		else $error("invalid class block was used");
	a_plogi_rx_size: assert property (rx_done_i && rx_plogi && cap_reg[4][31] && !login_reset_i
		|=> peer_rx_size_o[1] == $past(cap_reg[5][11:0]))
		else $error("receive size not taken");
	a_login_defaults: assert property (login_reset_i |=> peer_conc_seq_o[1] == 8'h01 && peer_e2e_credit_o[0] == 16'h0001
		&& peer_e2e_credit_o[1] == 16'h0000)
		else $error("defaults not restored");
	a_fab_prio_agreed: assert property (rx_done_i && rx_kind_i == csp_pkg::csp_flogi_acc && !login_reset_i
		&& cap_reg[0][31] && cap_reg[0][23] && loc_prio_i[0] |=> fab_prio_o[0] == csp_pkg::csp_prio_agreed)
		else $error("fabric priority not agreed");
	a_tx_prio_zero: assert property (!tx_frame_cls_i && fab_prio_o[0] != csp_pkg::csp_prio_agreed
		|=> tx_frame_prio_o == 8'h00)
		else $error("priority sent without agreement");

	c_tx_full_block: cover property (tx_valid_o && tx_ready_i && tx_index_o == 8'h14);
	c_plogi_commit: cover property (rx_done_i && rx_plogi ##1 peer_class_valid_o == 2'b11);
	c_fab_agreed: cover property (fab_prio_o[1] == csp_pkg::csp_prio_agreed);

endmodule // csp_codec

// ==== test/csp_peer_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Peer port model acting only as payload sink
// ----------------------------------------
module csp_peer_model (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic stall_i,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_index_i,
	input wire logic [31:0] tx_word_i,
	output logic tx_ready_o
);
	logic [31:0] got [13:20];
	integer seed = 32'h5a5a_1234;
	initial tx_ready_o = 1'b0;
	// Keep only class block words; slow mode stalls at random so words must stand
	always @(posedge clock_i) begin
		if (tx_valid_i && tx_ready_o && tx_index_i >= 8'h0D && tx_index_i <= 8'h14) begin
			got[tx_index_i] <= tx_word_i;
		end
		tx_ready_o <= #1 !reset_i && (!stall_i || $random(seed) % 2 != 0);
	end
endmodule // csp_peer_model

// ==== test/test_class_service_param_codec.sv ====
`timescale 1ns/1ps
module test_class_service_param_codec;
	logic clock_i = 0, reset_i = 1, login_reset_i = 0, loc_seqid_uniq_i = 0, loc_csync_i = 0, tx_start_i = 0;
	logic tx_ready_i, tx_valid_o, tx_busy_o, rx_valid_i = 0, rx_done_i = 0, fr_valid_i = 0, fr_cls_i = 0;
	logic fr_prio_en_i = 0, fr_prio_nz_i = 0, fr_csctl_nz_i = 0, fr_done_o, fr_accept_o, stall = 0;
	logic tx_frame_cls_i = 0, tx_frame_pref_i = 0, tx_frame_pref_o, acc;
	logic [1:0] loc_class_en_i = 0, loc_prio_i = 0, loc_pref_i = 0, peer_class_valid_o, peer_prio_o, peer_pref_o;
	logic [1:0] peer_seqid_uniq_o, peer_csync_o, fab_class_valid_o, fab_pref_o, fab_csync_o;
	logic [15:0] loc_init_ctl_i = 0, loc_rcp_ctl_i = 0, loc_e2e_credit_i = 0;
	logic [11:0] loc_rx_size_i = 0;
	logic [7:0] loc_conc_seq_i = 0, loc_open_seq_i = 0, tx_index_o, rx_index_i = 0, tx_frame_prio_i = 0, tx_frame_prio_o;
	logic [31:0] tx_word_o, rx_word_i = 0;
	logic [31:0] pw [0:7];
	logic [1:0][11:0] peer_rx_size_o;
	logic [1:0][7:0] peer_conc_seq_o, peer_open_seq_o;
	logic [1:0][15:0] peer_e2e_credit_o;
	csp_pkg::csp_kind_type tx_kind_i = csp_pkg::csp_plogi_req, rx_kind_i = csp_pkg::csp_plogi_req;
	csp_pkg::csp_prio_type [1:0] fab_prio_o;
	integer err_count = 0, n_compared = 0, seed = 32'hd7da_991b, i, c, k;

	csp_codec csp_codec_i (.*);
	csp_peer_model csp_peer_model_i (.clock_i(clock_i), .reset_i(reset_i), .stall_i(stall),
		.tx_valid_i(tx_valid_o), .tx_index_i(tx_index_o), .tx_word_i(tx_word_o), .tx_ready_o(tx_ready_i));

	always #5 clock_i = !clock_i;

	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task tick;
		@(posedge clock_i);
		#1;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task test_done;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Expected class block word; disabled class goes out as zeros
	function automatic logic [31:0] exp_word(input int kd, input int c, input int w);
		logic pl, fa;
		pl = kd < 2;
		fa = kd == 3;
		if (!loc_class_en_i[c]) return 32'h0000_0000;
		case (w)
			0: return {1'b1, 7'h00, loc_prio_i[c], loc_pref_i[c], 6'h00, fa ? 16'h0000 : loc_init_ctl_i};
			1: return {loc_rcp_ctl_i[15:4], loc_csync_i, pl & loc_seqid_uniq_i, loc_rcp_ctl_i[1:0],
				pl ? {4'h0, loc_rx_size_i} : 16'h0000};
			2: return fa ? 32'h0000_0000 : {8'h00, loc_conc_seq_i, c ? 16'h0000 : loc_e2e_credit_i};
			default: return fa ? 32'h0000_0000 : {8'h00, loc_open_seq_i, 16'h0000};
		endcase
	endfunction
	task rnd_loc;
		{loc_class_en_i, loc_prio_i, loc_pref_i, loc_seqid_uniq_i, loc_csync_i} = 8'($random(seed));
		loc_init_ctl_i = 16'($random(seed));
		loc_rcp_ctl_i = 16'($random(seed)) & 16'hFFFC; // Reserved bits kept clear
		{loc_rx_size_i, loc_conc_seq_i, loc_open_seq_i} = 28'($random(seed));
		loc_e2e_credit_i = 16'($random(seed));
	endtask
	task send(input int kd);
		tx_kind_i = csp_pkg::csp_kind_type'(kd);
		tx_start_i = 1;
		tick;
		tx_start_i = 0;
		for (k = 0; k < 300 && tx_busy_o === 1'b1; k++) tick;
		chk(tx_busy_o, 0, "busy stuck");
		for (k = 0; k < 8; k++) chk(csp_peer_model_i.got[13 + k], exp_word(kd, k / 4, k % 4), "tx");
	endtask
	// Words 12 and 21 carry junk that must not be kept
	task recv(input int kd);
		for (k = 12; k < 22; k++) begin
			rx_valid_i = 1;
			rx_index_i = 8'(k);
			rx_word_i = (k > 12 && k < 21) ? pw[k - 13] : 32'hFFFF_FFFF;
			tick;
		end
		rx_valid_i = 0;
		rx_kind_i = csp_pkg::csp_kind_type'(kd);
		rx_done_i = 1;
		tick;
		rx_done_i = 0;
	endtask
	// Invalid block must read back as login defaults
	task chk_peer(input int c);
		logic v;
		v = pw[c * 4][31];
		chk(peer_class_valid_o[c], v, "valid");
		chk(peer_prio_o[c], v & pw[c * 4][23], "prio");
		chk(peer_pref_o[c], v & pw[c * 4][22], "pref");
		chk(peer_csync_o[c], v & pw[c * 4 + 1][19], "csync");
		chk(peer_seqid_uniq_o[c], v & pw[c * 4 + 1][18], "seqid");
		chk(peer_rx_size_o[c], v ? pw[c * 4 + 1][11:0] : 12'h100, "size");
		chk(peer_conc_seq_o[c], v ? pw[c * 4 + 2][23:16] : 8'h01, "conc");
		chk(peer_e2e_credit_o[c], c ? 16'h0000 : v ? pw[2][15:0] : 16'h0001, "e2e");
		chk(peer_open_seq_o[c], v ? pw[c * 4 + 3][23:16] : 8'h01, "open");
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		for (k = 0; k < 8; k++) pw[k] = 0;
		repeat (5) @(posedge clock_i);
		#1;
		reset_i = 0;
		for (c = 0; c < 2; c++) chk_peer(c);
		chk(fab_prio_o[0], csp_pkg::csp_prio_none, "fab reset");
		$display("test defaults done");
		for (i = 0; i < 12; i++) begin
			rnd_loc;
			stall = i[0];
			send(i % 4);
		end
		$display("test transmit done");
		for (k = 0; k < 8; k++) pw[k] = $random(seed);
		recv(1);
		for (c = 0; c < 2; c++) chk_peer(c);
		login_reset_i = 1;
		tick;
		login_reset_i = 0;
		for (k = 0; k < 8; k++) pw[k] = 0;
		for (c = 0; c < 2; c++) chk_peer(c);
		$display("test receive done");
		for (i = 0; i < 4; i++) begin
			for (k = 0; k < 8; k++) pw[k] = $random(seed);
			pw[0][31] = 1;
			pw[0][23] = i[0];
			pw[4][31] = 0;
			loc_prio_i = {1'b1, i[1]};
			recv(3);
			chk(fab_prio_o[0], i, "fab prio");
			chk(fab_class_valid_o, 2'b01, "fab valid");
			chk(fab_prio_o[1], csp_pkg::csp_prio_fab_lacks, "fab inval");
			chk(fab_pref_o, {1'b0, pw[0][22]}, "fab pref");
			chk(fab_csync_o, {1'b0, pw[1][19]}, "fab csync");
		end
		recv(2);
		chk(fab_prio_o[0], csp_pkg::csp_prio_agreed, "fab req kept");
		$display("test fabric done");
		for (i = 0; i < 64; i++) begin
			{loc_class_en_i, loc_prio_i, loc_pref_i} = 6'($random(seed));
			{fr_cls_i, fr_prio_en_i, fr_prio_nz_i, fr_csctl_nz_i} = 4'($random(seed));
			c = fr_cls_i;
			acc = !((fr_prio_en_i & fr_prio_nz_i & !(loc_class_en_i[c] & loc_prio_i[c]))
				| (!fr_prio_en_i & fr_csctl_nz_i & !(loc_class_en_i[c] & loc_pref_i[c])));
			fr_valid_i = 1;
			tick;
			chk(fr_done_o, 1, "done");
			chk(fr_accept_o, acc, "accept");
		end
		fr_valid_i = 0;
		tick;
		chk(fr_done_o, 0, "done pulse");
		$display("test frame done");
		pw[0] = 32'h8080_0000;
		pw[4] = 32'h8000_0000;
		recv(0);
		for (i = 0; i < 16; i++) begin
			{loc_class_en_i, loc_pref_i, tx_frame_cls_i, tx_frame_pref_i} = 6'($random(seed));
			tx_frame_prio_i = 8'($random(seed)) | 8'h01;
			c = tx_frame_cls_i;
			tick;
			chk(tx_frame_prio_o, c ? 8'h00 : tx_frame_prio_i, "hdr prio");
			chk(tx_frame_pref_o, tx_frame_pref_i & loc_pref_i[c] & loc_class_en_i[c], "hdr pref");
		end
		$display("test header done");
		test_done;
	end

	// Whole run is a few hundred cycles
	initial begin
		#200000;
		err_count++;
		$display("BAD %0t watchdog", $time);
		test_done;
	end
endmodule // test_class_service_param_codec
